// ==== rtl/timer8_capture_event_counter.sv ====
/*
 8-bit timer / event counter / capture block with compare/capture
 register A and capture register B.
 Assumes control, data writes and register A read strobes come from a
 CPU-side register interface as plain ports, synchronous to sys_clk_i.
*/
`timescale 1ns/1ns
module timer8_capture_event_counter
   import timer8_pkg::*;
(
   input  wire logic            sys_clk_i,          // System clock, 10 MHz
   input  wire logic            rstn_i,             // Async reset, active low
   input  wire ctrl_write_type  ctrl_wr_i,          // Control word write
   input  wire logic            reg_a_we_i,         // Write strobe, register A
   input  wire logic [7:0]      reg_a_wdata_i,      // Write data, register A
   input  wire logic            reg_a_rd_i,         // Read strobe, register A
   input  wire logic [7:0]      reject_len_i,       // Noise reject length, cycles
   input  wire logic            timer_b_input_pin_i,// External pulse input
   output timer_ctrl_type       timer_b_control_o,  // Control word readback
   output logic [7:0]           compare_capture_reg_a_o, // Register A
   output logic [7:0]           capture_reg_b_o,    // Register B
   output logic [7:0]           count_o,            // Live counter
   output logic                 timer_b_interrupt_o // One-cycle interrupt
);

   // Decoding of the tap length for a select code
   function automatic logic [PRESCALE_W-1:0] tap_len(input logic [1:0] sel, input logic lp);
      logic [PRESCALE_W-1:0] len;
      len = PRESCALE_W'(TAP0_CYCLES - 1);
      if (!lp) begin
         unique case (sel)
            CLK_SEL_TAP1: len = PRESCALE_W'(TAP1_CYCLES - 1);
            CLK_SEL_TAP2: len = PRESCALE_W'(TAP2_CYCLES - 1);
            default:      len = PRESCALE_W'(TAP0_CYCLES - 1); // Code 11 acts as tap 0
         endcase
      end
      return len;
   endfunction

   timer_ctrl_type        ctrl_reg,  ctrl_next;   // Control word
   logic [7:0]            a_reg,     a_next;      // Compare/capture A
   logic [7:0]            b_reg,     b_next;      // Capture B
   logic [7:0]            cnt_reg,   cnt_next;    // Up-counter
   logic [PRESCALE_W-1:0] pre_reg,   pre_next;    // Prescaler
   logic                  lock_reg,  lock_next;   // Capture/overflow suspended
   logic                  irq_reg,   irq_next;    // Interrupt pulse
   logic                  tick;                   // Internal clock enable
   logic                  pin_rise;
   logic                  pin_fall;
   logic                  prim_edge;              // Primary edge in event and capture modes
   logic                  sec_edge;               // Opposite edge

   // Pin conditioner with programmable noise reject
   timer8_input_filter u_filter (
      .sys_clk_i    (sys_clk_i),
      .rstn_i       (rstn_i),
      .pin_i        (timer_b_input_pin_i),
      .reject_len_i (reject_len_i),
      .rise_o       (pin_rise),
      .fall_o       (pin_fall)
   );

   // Edge polarity: select bit chooses which edge is primary
   assign prim_edge = ctrl_reg.capture_edge_select ? pin_fall : pin_rise;
   assign sec_edge  = ctrl_reg.capture_edge_select ? pin_rise : pin_fall;

   // Prescaler: one-cycle tick at the selected tap
   always_comb begin
      tick     = (pre_reg >= tap_len(ctrl_reg.timer_b_clock_select, ctrl_reg.low_power));
      pre_next = tick ? '0 : pre_reg + 1'b1;
      if (ctrl_wr_i.we) begin
         pre_next = '0;                                     // Restart on reconfigure
      end
   end

   // Counter, capture and control next-state
   always_comb begin
      ctrl_next = ctrl_reg;
      a_next    = a_reg;
      b_next    = b_reg;
      cnt_next  = cnt_reg;
      lock_next = lock_reg;
      irq_next  = 1'b0;
      unique case (ctrl_reg.mode)
         MODE_TIMER: begin
            // Count tap, clear on match with A
            if (tick) begin
               if (cnt_reg == a_reg) begin
                  cnt_next = COUNT_ZERO;
                  irq_next = 1'b1;
               end else begin
                  cnt_next = cnt_reg + 8'h01;
               end
            end
         end
         MODE_EVENT: begin
            // Count primary pin edges, clear on match with A
            if (prim_edge) begin
               if (cnt_reg == a_reg) begin
                  cnt_next = COUNT_ZERO;
                  irq_next = 1'b1;
               end else begin
                  cnt_next = cnt_reg + 8'h01;
               end
            end
         end
         MODE_CAPTURE: begin
            // Free-running count, no compare
            if (tick) begin
               cnt_next = cnt_reg + 8'h01;
            end
            if (!lock_reg && prim_edge) begin
               a_next    = cnt_reg;
               cnt_next  = COUNT_ZERO;
               irq_next  = 1'b1;
               lock_next = 1'b1;
            end else if (!lock_reg && tick && cnt_reg == COUNT_FULL) begin
               a_next    = OVERFLOW_VAL;
               cnt_next  = COUNT_ZERO;
               irq_next  = 1'b1;
               lock_next = 1'b1;
            end
            // While locked the counter just wraps and keeps running
            if (sec_edge) begin
               b_next = cnt_reg;
            end
         end
         MODE_STOP: begin
            // Held: counter frozen
            cnt_next = cnt_reg;
         end
      endcase
      // Software capture request in timer and event modes, self-clearing
      if (ctrl_reg.software_capture_request) begin
         if (ctrl_reg.mode == MODE_TIMER || ctrl_reg.mode == MODE_EVENT) begin
            b_next = cnt_reg;
         end
         ctrl_next.software_capture_request = 1'b0;
      end
      // Reading A re-arms capture; a new lock in the same cycle wins
      if (reg_a_rd_i && !(lock_next && !lock_reg)) begin
         lock_next = 1'b0;
      end
      // Software writes
      if (ctrl_wr_i.we) begin
         ctrl_next = ctrl_wr_i.data;
         if (ctrl_wr_i.data.mode != ctrl_reg.mode) begin
            cnt_next  = COUNT_ZERO;                         // Fresh start on mode change
            lock_next = 1'b0;
         end
      end
      if (reg_a_we_i && ctrl_reg.mode != MODE_CAPTURE) begin
         a_next = reg_a_wdata_i;
      end
   end

   // Registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_reg <= '{software_capture_request: 1'b0, mode: MODE_STOP,
                       timer_b_clock_select: CLK_SEL_TAP0, capture_edge_select: 1'b0,
                       low_power: 1'b0};
         a_reg    <= COUNT_ZERO;
         b_reg    <= COUNT_ZERO;
         cnt_reg  <= COUNT_ZERO;
         pre_reg  <= '0;
         lock_reg <= 1'b0;
         irq_reg  <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         a_reg    <= a_next;
         b_reg    <= b_next;
         cnt_reg  <= cnt_next;
         pre_reg  <= pre_next;
         lock_reg <= lock_next;
         irq_reg  <= irq_next;
      end
   end

   // Outputs straight from registers
   assign timer_b_control_o       = ctrl_reg;
   assign compare_capture_reg_a_o = a_reg;
   assign capture_reg_b_o         = b_reg;
   assign count_o                 = cnt_reg;
   assign timer_b_interrupt_o     = irq_reg;

endmodule

// ==== rtl/timer8_pkg.sv ====
/*
 Package for the 8-bit timer / event counter / capture block.
 Holds mode codes, clock-select codes, bit positions, prescaler divide
 figures and the packed control carrier. Assumes a 10 MHz system clock.
*/
package timer8_pkg;

   // Operating modes of the counter
   typedef enum logic [1:0] {
      MODE_TIMER   = 2'b00,
      MODE_EVENT   = 2'b01,
      MODE_CAPTURE = 2'b10,
      MODE_STOP    = 2'b11
   } timer_mode_type;

   // Clock-select codes for the internal prescaler taps
   localparam logic [1:0] CLK_SEL_TAP0 = 2'h0;   // Slowest tap, only code in low-power modes
   localparam logic [1:0] CLK_SEL_TAP1 = 2'h1;
   localparam logic [1:0] CLK_SEL_TAP2 = 2'h2;

   // Bit position of the software capture request in the control word
   localparam int SOFTWARE_CAPTURE_REQUEST_BIT = 6;

   // System clock rate and tap periods (ns) at this rate
   localparam int SYS_CLK_HZ     = 10_000_000;
   localparam int SYS_PERIOD_NS  = 1_000_000_000 / SYS_CLK_HZ;
   localparam int TAP0_PERIOD_NS = 327_680;
   localparam int TAP1_PERIOD_NS = 81_920;
   localparam int TAP2_PERIOD_NS = 10_240;
   localparam int TAP0_CYCLES    = TAP0_PERIOD_NS / SYS_PERIOD_NS;
   localparam int TAP1_CYCLES    = TAP1_PERIOD_NS / SYS_PERIOD_NS;
   localparam int TAP2_CYCLES    = TAP2_PERIOD_NS / SYS_PERIOD_NS;
   localparam int PRESCALE_W     = 12;

   // Counter width and constants
   localparam int          DATA_W       = 8;
   localparam logic [7:0]  COUNT_ZERO   = 8'h00;
   localparam logic [7:0]  COUNT_FULL   = 8'hFF;
   localparam logic [7:0]  OVERFLOW_VAL = 8'hFF;
   localparam logic [7:0]  FILTER_ZERO  = 8'h00;

   // Control word as seen by the block
   typedef struct packed {
      logic           software_capture_request; // Bit 6: one-shot copy to B in timer and event modes
      timer_mode_type mode;                     // Operating mode
      logic [1:0]     timer_b_clock_select;     // Prescaler tap
      logic           capture_edge_select;      // 0 rising primary, 1 falling
      logic           low_power;                // Slow/sleep: only tap 0 usable
   } timer_ctrl_type;

   // Control write value with its strobe
   typedef struct packed {
      logic           we;
      timer_ctrl_type data;
   } ctrl_write_type;

endpackage

// ==== rtl/timer8_input_filter.sv ====
/*
 Input conditioner for the timer input pin: two-stage synchroniser,
 programmable noise reject, edge pulses. Assumes the pin is asynchronous
 to sys_clk_i and that reject_len_i is stable while in use.
*/
`timescale 1ns/1ns
module timer8_input_filter
   import timer8_pkg::*;
(
   input  wire logic        sys_clk_i,    // System clock
   input  wire logic        rstn_i,       // Async reset, active low
   input  wire logic        pin_i,        // Raw pin level
   input  wire logic [7:0]  reject_len_i, // Cycles the level must hold (0 = none)
   output logic             rise_o,       // One-cycle rising edge
   output logic             fall_o        // One-cycle falling edge
);

   logic       sync1_reg, sync1_next;     // First synchroniser stage
   logic       sync2_reg, sync2_next;     // Second synchroniser stage
   logic       level_reg, level_next;     // Filtered level
   logic [7:0] hold_reg,  hold_next;      // Stability counter
   logic       rise_reg,  rise_next;
   logic       fall_reg,  fall_next;

   // Next-state: filtered level changes once raw level held long enough
   always_comb begin
      sync1_next = pin_i;
      sync2_next = sync1_reg;
      level_next = level_reg;
      hold_next  = hold_reg;
      rise_next  = 1'b0;
      fall_next  = 1'b0;
      if (sync2_reg == level_reg) begin
         // Level agrees, restart stability count
         hold_next = FILTER_ZERO;
      end else if (hold_reg >= reject_len_i) begin
         // Held long enough: accept new level
         level_next = sync2_reg;
         hold_next  = FILTER_ZERO;
         rise_next  = sync2_reg;
         fall_next  = ~sync2_reg;
      end else begin
         hold_next = hold_reg + 8'h01;
      end
   end

   // Registers
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         level_reg <= 1'b0;
         hold_reg  <= FILTER_ZERO;
         rise_reg  <= 1'b0;
         fall_reg  <= 1'b0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         level_reg <= level_next;
         hold_reg  <= hold_next;
         rise_reg  <= rise_next;
         fall_reg  <= fall_next;
      end
   end

   assign rise_o = rise_reg;
   assign fall_o = fall_reg;

endmodule

// ==== sim/timer8_checker.sv ====
/* Port assertions for the timer block.
   Bound onto the top module; sees its ports only. */
`timescale 1ns/1ns
module timer8_checker
   import timer8_pkg::*;
(
   input wire logic           sys_clk_i,
   input wire logic           rstn_i,
   input wire ctrl_write_type ctrl_wr_i,
   input wire logic           reg_a_we_i,
   input wire logic [7:0]     reg_a_wdata_i,
   input wire logic           reg_a_rd_i,
   input wire logic [7:0]     reject_len_i,
   input wire logic           timer_b_input_pin_i,
   input wire timer_ctrl_type timer_b_control_o,
   input wire logic [7:0]     compare_capture_reg_a_o,
   input wire logic [7:0]     capture_reg_b_o,
   input wire logic [7:0]     count_o,
   input wire logic           timer_b_interrupt_o
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);
   logic cap;      // Capture mode active
   logic irq;      // Interrupt pulse
   logic lock_reg; // Set by a capture-mode interrupt until A is read or the control word is written
   assign cap = timer_b_control_o.mode == MODE_CAPTURE;
   assign irq = timer_b_interrupt_o;
   // Tracks the capture lock from the ports
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         lock_reg <= 1'b0;
      else if (ctrl_wr_i.we || reg_a_rd_i)
         lock_reg <= 1'b0;
      else if (irq && cap)
         lock_reg <= 1'b1;
   end
   AST_IRQ_PULSE:
      assert property (irq |=> !irq) else $error("interrupt longer than one cycle");
   AST_IRQ_CLEARS:
      assert property (irq |-> count_o == 8'h00) else $error("counter not cleared at interrupt");
   AST_COUNT_STEP:
      assert property ($changed(count_o) |-> count_o == $past(count_o) + 8'h01 || count_o == 8'h00)
         else $error("counter jumped");
   AST_A_CAPTURE_IRQ:
      assert property (cap && $changed(compare_capture_reg_a_o) |-> ##[0:1] irq) else $error("A loaded without interrupt");
   AST_A_WRITTEN_ONLY:
      assert property (!cap && $changed(compare_capture_reg_a_o) |-> $past(reg_a_we_i)) else $error("A changed unwritten");
   AST_REQUEST_CLEARS:
      assert property (timer_b_control_o.software_capture_request |-> ##[1:2] !timer_b_control_o.software_capture_request)
         else $error("capture request not cleared");
   AST_B_KEEPS_COUNT:
      assert property (cap && $changed(capture_reg_b_o) |-> capture_reg_b_o == count_o
                       || capture_reg_b_o + 8'h01 == count_o) else $error("B load cleared the counter");
   AST_LOCK_QUIET:
      assert property (lock_reg && cap |-> !irq) else $error("interrupt while capture locked");
endmodule

bind timer8_capture_event_counter timer8_checker u_checker (
   .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ctrl_wr_i(ctrl_wr_i), .reg_a_we_i(reg_a_we_i),
   .reg_a_wdata_i(reg_a_wdata_i), .reg_a_rd_i(reg_a_rd_i), .reject_len_i(reject_len_i),
   .timer_b_input_pin_i(timer_b_input_pin_i), .timer_b_control_o(timer_b_control_o),
   .compare_capture_reg_a_o(compare_capture_reg_a_o), .capture_reg_b_o(capture_reg_b_o),
   .count_o(count_o), .timer_b_interrupt_o(timer_b_interrupt_o));

// ==== sim/timer8_pulse_source.sv ====
/* External pulse source on the timer input pin.
   Assumes the caller times its levels in system clock cycles. */
`timescale 1ns/1ns
module timer8_pulse_source (
   input  wire logic sys_clk_i, // System clock
   output logic      pin_o      // Pulse output
);
   localparam int MIN_LEVEL = 8; // Above two cycles and below clock/16 rate
   initial pin_o = 1'b0;
   // Set a level at the falling edge and hold it
   task automatic drive(input logic v, input int hold);
      @(negedge sys_clk_i);
      pin_o = v;
      repeat (hold < MIN_LEVEL ? MIN_LEVEL : hold) @(negedge sys_clk_i);
   endtask
endmodule

// ==== sim/test_timer8_capture_event_counter.sv ====
/* Self-checking bench for the timer block.
   Assumes a 10 MHz clock and the pulse source model. */
`timescale 1ns/1ns
module test_timer8_capture_event_counter;
   import timer8_pkg::*;
   localparam int T = TAP2_CYCLES; // Fast tick in cycles
   logic           sys_clk_i, rstn_i, reg_a_we_i, reg_a_rd_i, pin, irq;
   logic [7:0]     reg_a_wdata_i, reject_len_i, a_o, b_o, count_o, b_last;
   ctrl_write_type ctrl_wr_i;
   timer_ctrl_type ctrl_o;
   logic [8:0]     qa[$], qb[$]; // Expected A and B, bit 8 allows one count of slack
   int             errors, compares, n, tap;
   logic [2:0]     cfg[4] = '{3'b010, 3'b001, 3'b000, 3'b110}; // Low power, clock select
   timer8_capture_event_counter DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ctrl_wr_i(ctrl_wr_i),
      .reg_a_we_i(reg_a_we_i), .reg_a_wdata_i(reg_a_wdata_i), .reg_a_rd_i(reg_a_rd_i),
      .reject_len_i(reject_len_i), .timer_b_input_pin_i(pin), .timer_b_control_o(ctrl_o),
      .compare_capture_reg_a_o(a_o), .capture_reg_b_o(b_o), .count_o(count_o), .timer_b_interrupt_o(irq));
   timer8_pulse_source src (.sys_clk_i(sys_clk_i), .pin_o(pin));
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task automatic check(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic take(ref logic [8:0] q[$], input logic [7:0] v);
      logic [8:0] e;
      if (q.size() == 0) begin
         check(1'b0, "unexpected result");
         return;
      end
      e = q.pop_front();
      check(v === e[7:0] || (e[8] && (v === e[7:0] + 8'h01 || v === e[7:0] - 8'h01)), "captured value");
   endtask
   task automatic wctl(input timer_mode_type m, input logic [1:0] sel, input logic lp, sc, es);
      @(negedge sys_clk_i);
      ctrl_wr_i.data = '{sc, m, sel, es, lp};
      ctrl_wr_i.we = 1'b1;
      @(negedge sys_clk_i);
      ctrl_wr_i.we = 1'b0;
   endtask
   task automatic wa(input logic [7:0] v);
      @(negedge sys_clk_i);
      reg_a_wdata_i = v;
      reg_a_we_i = 1'b1;
      @(negedge sys_clk_i);
      reg_a_we_i = 1'b0;
   endtask
   task automatic rd_a;
      @(negedge sys_clk_i);
      reg_a_rd_i = 1'b1;
      @(negedge sys_clk_i);
      reg_a_rd_i = 1'b0;
   endtask
   // Wait for an interrupt pulse, return cycles waited
   task automatic wirq(input int lim, output int k);
      for (k = 1; k <= lim; k++) begin
         @(posedge sys_clk_i);
         if (irq === 1'b1)
            break;
      end
      if (k > lim)
         check(1'b0, "no interrupt");
      @(negedge sys_clk_i);
   endtask
   task automatic print_verdict;
      errors += qa.size() + qb.size();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Results are compared as they appear
   always @(negedge sys_clk_i) begin
      if (irq === 1'b1) begin
         take(qa, a_o);
         check(count_o === 8'h00, "counter not cleared");
      end
      if (b_o !== b_last)
         take(qb, b_o);
      b_last = b_o;
   end
   initial begin
      #(90_000 * 100);
      check(1'b0, "watchdog expired");
      print_verdict();
   end
   initial begin
      void'($urandom(43));
      {rstn_i, reg_a_we_i, reg_a_rd_i, reg_a_wdata_i, b_last} = '0;
      ctrl_wr_i = '0;
      reject_len_i = 8'($urandom_range(3));
      repeat (4) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      check(a_o === 8'h00 && b_o === 8'h00 && count_o === 8'h00, "reset value");
      // Timer period on each tap and the low-power override
      wa(8'h01);
      foreach (cfg[i]) begin
         tap = cfg[i][2] || cfg[i][1:0] == 2'h0 ? TAP0_CYCLES : cfg[i][1:0] == 2'h1 ? TAP1_CYCLES : T;
         qa.push_back(9'h001);
         qa.push_back(9'h001);
         wctl(MODE_TIMER, cfg[i][1:0], cfg[i][2], 1'b0, 1'b0);
         wirq(3 * tap, n);
         wirq(3 * tap, n);
         check(n == 2 * tap, "timer period");
      end
      // Software capture of the live count
      wctl(MODE_STOP, 2'h2, 1'b0, 1'b0, 1'b0);
      wa(8'hC8);
      wctl(MODE_TIMER, 2'h2, 1'b0, 1'b0, 1'b0);
      repeat (5 * T + 50) @(negedge sys_clk_i);
      qb.push_back(9'h105);
      wctl(MODE_TIMER, 2'h2, 1'b0, 1'b1, 1'b0);
      repeat (3) @(negedge sys_clk_i);
      check(ctrl_o.software_capture_request === 1'b0, "capture request stuck");
      // Event counting on either edge
      for (int es = 0; es < 2; es++) begin
         n = $urandom_range(4, 2);
         wctl(MODE_STOP, 2'h0, 1'b0, 1'b0, 1'b0);
         wa(8'(n));
         wctl(MODE_EVENT, 2'h0, 1'b0, 1'b0, 1'(es));
         // Counter runs 0..A, so the match needs A+1 primary edges
         repeat (n) begin
            src.drive(1'b1, 12);
            src.drive(1'b0, 12);
         end
         if (es == 0)
            qa.push_back(9'(n));
         src.drive(1'b1, 12);
         if (es == 1)
            qa.push_back(9'(n));
         src.drive(1'b0, 12);
      end
      // Capture: width, period, lock and overflow
      wctl(MODE_STOP, 2'h2, 1'b0, 1'b0, 1'b0);
      wctl(MODE_CAPTURE, 2'h2, 1'b0, 1'b0, 1'b0);
      wa(8'($urandom)); // Refused while capturing
      check(a_o === 8'(n), "A write accepted in capture mode");
      repeat (10 * T + 50) @(negedge sys_clk_i);
      qa.push_back(9'h10A);
      src.drive(1'b1, 3 * T);
      qb.push_back(9'h103);
      src.drive(1'b0, 4 * T);
      src.drive(1'b1, 2 * T); // Ignored while A is unread
      rd_a(); // B already taken first
      qb.push_back(9'h109);
      src.drive(1'b0, 2 * T);
      qa.push_back(9'h10B);
      src.drive(1'b1, 12);
      rd_a();
      qa.push_back(9'h0FF);
      wirq(257 * T, n);
      print_verdict();
   end
endmodule
